// ---- dv/serial_peer.sv ----
// far-side serial peripheral: takes words from so, sends words on si
// assumes: pin idles high, bench fills send_q and reads got_q
`timescale 1ns/10ps
module serial_peer (
  input  wire logic       sck_out_i,
  input  wire logic       sck_oe_i,
  input  wire logic       so_i,
  input  wire logic [3:0] nbits_i,
  output logic            si_o,
  output logic            sck_line_o
);
  logic [7:0] send_q[$];
  logic [7:0] got_q[$];
  logic [7:0] cur;
  logic [7:0] acc;
  logic       ext_clk = 1'b1;
  int         tx_n = 0;
  int         rx_n = 0;
  initial si_o = 1'b1;
  // =====================================
  // shared clock pin
  assign sck_line_o = (sck_oe_i === 1'b1) ? sck_out_i : ext_clk;
  always @(negedge sck_line_o) begin
    if (tx_n == 0) cur = (send_q.size() > 0) ? send_q.pop_front() : 8'hA5;
    si_o <= cur[tx_n];
    tx_n = (tx_n + 1) % nbits_i;
  end
  always @(posedge sck_line_o) begin
    #150;
    acc[rx_n] = so_i;
    rx_n = rx_n + 1;
    if (rx_n == nbits_i) begin
      got_q.push_back(acc & ((nbits_i == 4'h4) ? 8'h0F : 8'hFF));
      rx_n = 0;
      #200 si_o = ~si_o;
    end
  end
  // =====================================
  // bench controls
  task automatic run_ext(input int n);
    #37;
    repeat (n) begin
      #400 ext_clk = 1'b0;
      #400 ext_clk = 1'b1;
    end
  endtask
  task automatic flush();
    send_q.delete();
    got_q.delete();
    tx_n = 0;
    rx_n = 0;
  endtask
endmodule

// ---- dv/tb_sync_serial_buffered.sv ----
// bench for the buffered synchronous serial block
// assumes: package and header compiled first, serial_peer on the far side
`timescale 1ns/10ps
`include "sio_regs.svh"
module tb_sync_serial_buffered;
  import sio_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  bus_addr_t  addr = '0;
  bus_data_t  wdata = '0;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  bus_data_t  rdata;
  bus_data_t  d;
  logic       sck_out, sck_oe, so, si, sck_line, irq;
  logic [3:0] nbits = 4'h8;
  logic [7:0] mem[8];
  logic [7:0] sent[8];
  logic [2:0] t_mode[5] = '{`MODE_TX8, `MODE_TX4, `MODE_TXRX8, `MODE_RX8, `MODE_RX4};
  logic [2:0] t_clk[5]  = '{3'h5, 3'h5, 3'h5, 3'h4, 3'h3};
  logic [2:0] t_cnt[5]  = '{3'h7, 3'h2, 3'h7, 3'h3, 3'h1};
  int         n_mismatch = 0;
  int         checks_done = 0;
  int         seed = 32'h2BA0;
  int         cycles = 0;
  int         cyc;
  always #50 clk = ~clk;
  sync_serial_buffered DUT (.sys_clk_i(clk), .reset_i(rst), .bus_addr_i(addr), .bus_wdata_i(wdata),
    .bus_wr_i(wr), .bus_rd_i(rd), .bus_rdata_o(rdata), .sck_in_i(sck_line), .sck_out_o(sck_out),
    .sck_oe_o(sck_oe), .si_i(si), .so_o(so), .serial_done_irq_o(irq));
  serial_peer u_peer (.sck_out_i(sck_out), .sck_oe_i(sck_oe), .so_i(so), .nbits_i(nbits), .si_o(si),
    .sck_line_o(sck_line));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      n_mismatch = n_mismatch + 1;
      summarize();
    end
  end
  // =====================================
  // checks and bus cycles
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    checks_done = checks_done + 1;
    if (g !== e) begin
      n_mismatch = n_mismatch + 1;
      $display("BAD %s expected %0h seen %0h", w, e, g);
    end
  endtask
  task automatic wr_reg(input bus_addr_t a, input bus_data_t v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input bus_addr_t a, output bus_data_t v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask
  task automatic wait_irq(output int n);
    n = 0;
    while (irq !== 1'b1 && n < 20000) begin
      @(negedge clk);
      n = n + 1;
    end
    if (n >= 20000) chk("irq", 1, 0);
  endtask
  // =====================================
  // reference model of one block
  function automatic int exp_cyc(input logic [2:0] c, input int n, input logic [1:0] w);
    int k[6] = '{13, 8, 7, 6, 5, 4};
    int h;
    h = 1 << (k[c] - 1);
    return n * 2 * nbits * h + (n - 1) * 16 * ((1 << w) - 1) * h;
  endfunction
  task automatic setup(input logic [2:0] m, c, n, input logic [1:0] w);
    u_peer.flush();
    nbits = (m == `MODE_TX4 || m == `MODE_RX4) ? 4'h4 : 4'h8;
    for (int k = 0; k < 8; k++) begin
      mem[k] = 8'($random(seed));
      sent[k] = 8'($random(seed));
      u_peer.send_q.push_back(sent[k]);
      wr_reg(`ADDR_BUF_BASE + 16'(k), mem[k]);
    end
    wr_reg(`ADDR_CONTROL_ONE, {2'b01, m, c});
    wr_reg(`ADDR_CONTROL_TWO, {3'b000, w, n});
  endtask
  task automatic start(input logic [2:0] m, c);
    wr_reg(`ADDR_CONTROL_ONE, {2'b10, m, c});
  endtask
  task automatic abort_chk(input logic [2:0] m, c);
    wr_reg(`ADDR_CONTROL_ONE, {2'b01, m, c});
    rd_reg(`ADDR_STATUS, d);
    chk("status after abort", 0, d);
  endtask
  task automatic verify(input logic [2:0] m, input int n);
    logic [7:0] msk;
    msk = (nbits == 4'h4) ? 8'h0F : 8'hFF;
    chk("word count", n, u_peer.got_q.size());
    for (int k = 0; k < n; k++) begin
      if (m inside {`MODE_TX8, `MODE_TX4, `MODE_TXRX8}) chk("sent word", mem[k] & msk, u_peer.got_q[k]);
      if (m inside {`MODE_TXRX8, `MODE_RX8, `MODE_RX4}) begin
        rd_reg(`ADDR_BUF_BASE + 16'(k), d);
        chk("stored word", sent[k] & msk, d);
      end
    end
    if (n < 8) begin
      rd_reg(`ADDR_BUF_BASE + 16'(n), d);
      chk("spare byte", mem[n], d);
    end
  endtask
  task automatic run(input logic [2:0] m, c, n, input logic [1:0] w);
    int e;
    setup(m, c, n, w);
    start(m, c);
    wait_irq(cyc);
    e = exp_cyc(c, n + 1, w);
    chk("block time", 1, cyc >= e && cyc <= e + 2 * n + 8);
    rd_reg(`ADDR_STATUS, d);
    chk("status waiting", 8'h80, d);
    abort_chk(m, c);
    verify(m, n + 1);
  endtask
  // =====================================
  // scenarios
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk("so idle", 1, so);
    chk("sck idle", 1, sck_out);
    rd_reg(`ADDR_STATUS, d);
    chk("status reset", 0, d);
    rd_reg(`ADDR_CONTROL_ONE, d);
    chk("control read", 0, d);
    rd_reg(16'h2000, d);
    chk("unmapped read", 0, d);
    $display("test reset done");
    for (int i = 0; i < 5; i++) run(t_mode[i], t_clk[i], t_cnt[i], 2'h0);
    $display("test modes done");
    for (int w = 1; w < 4; w++) run(`MODE_TXRX8, 3'h5, 3'h1, 2'(w));
    $display("test frame wait done");
    run(`MODE_TX8, 3'h5, 3'h1, 2'h0);
    u_peer.flush();
    start(`MODE_TX8, 3'h5);
    wait_irq(cyc);
    rd_reg(`ADDR_STATUS, d);
    chk("status held", 8'h80, d);
    wr_reg(`ADDR_BUF_BASE, 8'h5A);
    wait_irq(cyc);
    abort_chk(`MODE_TX8, 3'h5);
    chk("words after resume", 4, u_peer.got_q.size());
    chk("resumed word", 8'h5A, u_peer.got_q[2]);
    $display("test auto wait done");
    setup(`MODE_TX8, 3'h5, 3'h7, 2'h0);
    start(`MODE_TX8, 3'h5);
    rd_reg(`ADDR_STATUS, d);
    chk("status busy", 8'hC0, d);
    wr_reg(`ADDR_CONTROL_ONE, {2'b00, `MODE_TX8, 3'h5});
    for (int i = 0; i < 100 && d !== 8'h00; i++) rd_reg(`ADDR_STATUS, d);
    chk("status after stop", 0, d);
    verify(`MODE_TX8, 1);
    $display("test stop done");
    setup(`MODE_TX8, 3'h5, 3'h7, 2'h0);
    start(`MODE_TX8, 3'h5);
    repeat (40) @(posedge clk);
    abort_chk(`MODE_TX8, 3'h5);
    repeat (200) @(posedge clk);
    chk("words after abort", 0, u_peer.got_q.size());
    chk("sck after abort", 1, sck_out);
    $display("test abort done");
    setup(`MODE_TX8, `CLK_RESERVED, 3'h0, 2'h0);
    start(`MODE_TX8, `CLK_RESERVED);
    rd_reg(`ADDR_STATUS, d);
    chk("reserved clock", 0, d);
    setup(`MODE_TX8, `CLK_EXTERNAL, 3'h1, 2'h0);
    start(`MODE_TX8, `CLK_EXTERNAL);
    chk("pin released", 0, sck_oe);
    u_peer.run_ext(16);
    wait_irq(cyc);
    abort_chk(`MODE_TX8, `CLK_EXTERNAL);
    verify(`MODE_TX8, 2);
    $display("test clock source done");
    summarize();
  end
endmodule

// ---- rtl/sio_pkg.sv ----
// types shared by the serial block
// assumes: compiled before the design modules
package sio_pkg;
  typedef logic [15:0] bus_addr_t;
  typedef logic [7:0]  bus_data_t;
  typedef logic [2:0]  sio_mode_t;
  typedef enum logic [1:0] {
    S_IDLE,
    S_SHIFT,
    S_AUTO_WAIT,
    S_FRAME_GAP
  } sio_state_e;
endpackage

// ---- rtl/sio_regs.svh ----
// register map, field positions, reset values and divider counts of the serial block
// assumes: included by bare name from the design files
`ifndef SIO_REGS_SVH
`define SIO_REGS_SVH

// =====================================================
// register addresses
`define ADDR_CONTROL_ONE   16'h1F95
`define ADDR_CONTROL_TWO   16'h1F96
`define ADDR_STATUS        16'h1F97
`define ADDR_BUF_BASE      16'h1F98
`define ADDR_BUF_LAST      16'h1F9F

// =====================================================
// field positions
`define C1_START           7
`define C1_ABORT           6
`define C1_MODE_HI         5
`define C1_MODE_LO         3
`define C1_CLK_HI          2
`define C1_CLK_LO          0
`define C2_WAIT_HI         4
`define C2_WAIT_LO         3
`define C2_COUNT_HI        2
`define C2_COUNT_LO        0
`define ST_XFER            7
`define ST_SHIFT           6

// =====================================================
// reset values and encodings
`define CONTROL_ONE_RESET  8'h00
`define CONTROL_TWO_RESET  8'h00
`define READ_ZERO          8'h00
`define MODE_TX8           3'h0
`define MODE_TX4           3'h2
`define MODE_TXRX8         3'h4
`define MODE_RX8           3'h5
`define MODE_RX4           3'h6
`define CLK_RESERVED       3'h6
`define CLK_EXTERNAL       3'h7
`define WAIT_NONE          2'h0
`define WAIT_X2            2'h1
`define WAIT_X4            2'h2
`define BIT_LAST8          3'h7
`define BIT_LAST4          3'h3
`define SCK_IDLE           1'b1

// =====================================================
// half serial clock periods in system clocks, minus one
`define HALF_DIV13         13'h0FFF
`define HALF_DIV8          13'h007F
`define HALF_DIV7          13'h003F
`define HALF_DIV6          13'h001F
`define HALF_DIV5          13'h000F
`define HALF_DIV4          13'h0007

// frame pause in half serial clocks, minus one: (mult-1) words of 16 halves
`define GAP_X2             7'h0F
`define GAP_X4             7'h2F
`define GAP_X8             7'h6F

`endif

// ---- rtl/sio_sync.sv ----
// two flip-flop synchroniser for one pin input
// assumes: input comes from outside the sys_clk_i domain
`timescale 1ns/10ps
module sio_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_i,
  input  wire logic pin_i,
  output logic      sync_o
);
  logic meta;

  // =====================================================
  // synchroniser chain
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      meta   <= RESET_VAL;
      sync_o <= RESET_VAL;
    end else begin
      meta   <= pin_i;
      sync_o <= meta;
    end
  end
endmodule

// ---- rtl/sync_serial_buffered.sv ----
// clocked synchronous serial interface with an eight-byte data buffer
// assumes: one 10 MHz system clock, plain register port, serial pins from outside
//
// Local design decision: strobed register access.
`timescale 1ns/10ps
`include "sio_regs.svh"

// What this block does
// - one eight-byte buffer serves transmit and receive, up to 64 bits per block
// - buffer sits at eight consecutive byte addresses, words are bytes or nibbles
// - interrupt pulses once the programmed word count has moved
// - internal clock eight-bit receive modes may pause after each word
// - wait code 00/01/10/11 gives frame time of 1/2/4/8 data times
// - writing start 1 starts a transfer, writing 0 requests a stop
// - abort bit ends the transfer and clears itself
// - mode field selects 8/4-bit transmit, 8-bit transmit/receive, 8/4-bit receive
// - clock select picks fc divided by a power of two, or the pin
// - word count n moves n plus one words from the lowest address
// - four-bit modes use low nibbles and receive zeros into high nibbles
// - transmit and receive walk the buffer in ascending address order
// - the word count stays programmed after a transfer
// - status bit 7 shows transfer active, bit 6 shows shifting
// - after start cleared, active flag drops at the end of the current word, at once during a pause, or on abort
// - data shift LSB first, out on falling edge, in on rising edge
// - internal clock halts until software touches the buffer when late
// - abort ends at once, stop lets the current word finish
module sync_serial_buffered (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire sio_pkg::bus_addr_t bus_addr_i,
  input  wire sio_pkg::bus_data_t bus_wdata_i,
  input  wire logic              bus_wr_i,
  input  wire logic              bus_rd_i,
  output sio_pkg::bus_data_t     bus_rdata_o,
  input  wire logic              sck_in_i,
  output logic                   sck_out_o,
  output logic                   sck_oe_o,
  input  wire logic              si_i,
  output logic                   so_o,
  output logic                   serial_done_irq_o
);
  import sio_pkg::*;

  // =====================================================
  // storage and control state
  logic [7:0]  data_buffer_area [0:7];
  logic        xfer_start_bit, xfer_abort_bit, go_req, touched;
  sio_mode_t   xfer_mode_field;
  logic [2:0]  clk_sel, word_count, bit_cnt, word_idx;
  logic [1:0]  wait_sel;
  sio_state_e  state;
  logic        xfer_active_flag, shift_active_flag;
  logic [12:0] div_cnt, half_lim;
  logic        half_tick, sck_sync, sck_prev, si_sync;
  logic [7:0]  shreg, next_shreg;
  logic [6:0]  gap_cnt, gap_lim;

  // =====================================================
  // decode
  logic [2:0]  buf_idx;
  logic        buf_hit, wr_c1, wr_c2, internal, four, rx_en, tx_en, gap_on;
  logic        fall, rise, last_bit, word_end, block_end, sw_access;

  assign buf_hit  = (bus_addr_i >= `ADDR_BUF_BASE) && (bus_addr_i <= `ADDR_BUF_LAST);
  assign buf_idx  = bus_addr_i[2:0];
  assign wr_c1    = bus_wr_i && (bus_addr_i == `ADDR_CONTROL_ONE);
  assign wr_c2    = bus_wr_i && (bus_addr_i == `ADDR_CONTROL_TWO);
  assign internal = (clk_sel != `CLK_EXTERNAL);
  assign four  = (xfer_mode_field == `MODE_TX4) || (xfer_mode_field == `MODE_RX4);
  assign rx_en = (xfer_mode_field == `MODE_TXRX8) || (xfer_mode_field == `MODE_RX8) ||
                 (xfer_mode_field == `MODE_RX4);
  assign tx_en = (xfer_mode_field == `MODE_TX8) || (xfer_mode_field == `MODE_TX4) ||
                 (xfer_mode_field == `MODE_TXRX8);
  // frame pause only with internal clock in eight-bit receive modes
  assign gap_on = internal && (wait_sel != `WAIT_NONE) &&
                  ((xfer_mode_field == `MODE_RX8) || (xfer_mode_field == `MODE_TXRX8));
  assign xfer_active_flag  = (state != S_IDLE);
  assign shift_active_flag = (state == S_SHIFT);
  assign sck_oe_o = internal;
  assign sw_access = buf_hit && (rx_en ? bus_rd_i : bus_wr_i);

  // =====================================================
  // pin synchronisers
  sio_sync #(.RESET_VAL(`SCK_IDLE)) sck_sync_u (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .pin_i     (sck_in_i),
    .sync_o    (sck_sync)
  );

  sio_sync #(.RESET_VAL(1'b0)) si_sync_u (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .pin_i     (si_i),
    .sync_o    (si_sync)
  );

  // =====================================================
  // control registers
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      {xfer_start_bit, xfer_abort_bit, xfer_mode_field, clk_sel} <= `CONTROL_ONE_RESET;
      go_req <= 1'b0;
    end else begin
      go_req <= wr_c1 && bus_wdata_i[`C1_START] && !bus_wdata_i[`C1_ABORT];
      if (wr_c1) begin
        xfer_start_bit  <= bus_wdata_i[`C1_START];
        xfer_abort_bit  <= bus_wdata_i[`C1_ABORT];
        xfer_mode_field <= bus_wdata_i[`C1_MODE_HI:`C1_MODE_LO];
        clk_sel         <= bus_wdata_i[`C1_CLK_HI:`C1_CLK_LO];
      end else if (xfer_abort_bit) begin
        xfer_abort_bit <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      {wait_sel, word_count} <= 5'(`CONTROL_TWO_RESET);
    end else if (wr_c2) begin
      wait_sel   <= bus_wdata_i[`C2_WAIT_HI:`C2_WAIT_LO];
      word_count <= bus_wdata_i[`C2_COUNT_HI:`C2_COUNT_LO];
    end
  end

  // =====================================================
  // serial clock divider
  always_comb begin
    case (clk_sel)
      3'h0:    half_lim = `HALF_DIV13;
      3'h1:    half_lim = `HALF_DIV8;
      3'h2:    half_lim = `HALF_DIV7;
      3'h3:    half_lim = `HALF_DIV6;
      3'h4:    half_lim = `HALF_DIV5;
      default: half_lim = `HALF_DIV4;
    endcase
  end

  assign half_tick = (div_cnt == half_lim);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      div_cnt <= 13'h0000;
    end else if (((state != S_SHIFT) && (state != S_FRAME_GAP)) || half_tick) begin
      div_cnt <= 13'h0000;
    end else begin
      div_cnt <= div_cnt + 13'h0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      sck_out_o <= `SCK_IDLE;
      sck_prev  <= `SCK_IDLE;
    end else begin
      sck_prev <= sck_sync;
      if (state != S_SHIFT) begin
        sck_out_o <= `SCK_IDLE;
      end else if (internal && half_tick) begin
        sck_out_o <= !sck_out_o;
      end
    end
  end

  // =====================================================
  // shift edges
  always_comb begin
    if (state != S_SHIFT) begin
      fall = 1'b0;
      rise = 1'b0;
    end else if (internal) begin
      fall = half_tick && sck_out_o;
      rise = half_tick && !sck_out_o;
    end else begin
      fall = sck_prev && !sck_sync;
      rise = !sck_prev && sck_sync;
    end
  end

  assign last_bit  = (bit_cnt == (four ? `BIT_LAST4 : `BIT_LAST8));
  assign word_end  = rise && last_bit;
  assign block_end = word_end && (word_idx == word_count);
  // receive shifts in at the top of the word, low nibble only in four-bit modes
  assign next_shreg = four ? {4'h0, si_sync, shreg[3:1]} : {si_sync, shreg[7:1]};

  // =====================================================
  // sequencer
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state <= S_IDLE;
    end else if (xfer_abort_bit) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          if (go_req && (clk_sel != `CLK_RESERVED)) begin
            state <= S_SHIFT;
          end
        end
        S_SHIFT: begin
          if (word_end) begin
            if (!xfer_start_bit) begin
              state <= S_IDLE;
            end else if (block_end && internal && !touched) begin
              state <= S_AUTO_WAIT;
            end else if (gap_on) begin
              state <= S_FRAME_GAP;
            end
          end
        end
        S_AUTO_WAIT: begin
          if (!xfer_start_bit) begin
            state <= S_IDLE;
          end else if (touched) begin
            state <= S_SHIFT;
          end
        end
        S_FRAME_GAP: begin
          if (!xfer_start_bit) begin
            state <= S_IDLE;
          end else if (half_tick && (gap_cnt == gap_lim)) begin
            state <= S_SHIFT;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // =====================================================
  // frame pause counter
  always_comb begin
    case (wait_sel)
      `WAIT_X2: gap_lim = `GAP_X2;
      `WAIT_X4: gap_lim = `GAP_X4;
      default:  gap_lim = `GAP_X8;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      gap_cnt <= 7'h00;
    end else if (state != S_FRAME_GAP) begin
      gap_cnt <= 7'h00;
    end else if (half_tick) begin
      gap_cnt <= gap_cnt + 7'h01;
    end
  end

  // =====================================================
  // software touch since last block end, set wins over clear
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      touched <= 1'b0;
    end else if (sw_access) begin
      touched <= 1'b1;
    end else if ((state == S_IDLE) || block_end || ((state == S_AUTO_WAIT) && touched)) begin
      touched <= 1'b0;
    end
  end

  // =====================================================
  // shift datapath
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      bit_cnt  <= 3'h0;
      word_idx <= 3'h0;
      shreg    <= 8'h00;
      so_o     <= `SCK_IDLE;
    end else if (state == S_IDLE) begin
      bit_cnt  <= 3'h0;
      word_idx <= 3'h0;
      shreg    <= data_buffer_area[0];
    end else if ((state == S_AUTO_WAIT) && touched) begin
      shreg <= data_buffer_area[0];
    end else begin
      if (fall) begin
        so_o <= tx_en ? shreg[0] : `SCK_IDLE;
      end
      if (rise) begin
        bit_cnt <= last_bit ? 3'h0 : bit_cnt + 3'h1;
        shreg   <= next_shreg;
      end
      if (word_end) begin
        word_idx <= block_end ? 3'h0 : word_idx + 3'h1;
        shreg    <= data_buffer_area[block_end ? 3'h0 : word_idx + 3'h1];
      end
    end
  end

  // =====================================================
  // data buffer
  always_ff @(posedge sys_clk_i) begin
    if (bus_wr_i && buf_hit) begin
      data_buffer_area[buf_idx] <= bus_wdata_i;
    end
    if (word_end && rx_en) begin
      data_buffer_area[word_idx] <= next_shreg;
    end
  end

  // =====================================================
  // interrupt and read port
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      serial_done_irq_o <= 1'b0;
    end else begin
      serial_done_irq_o <= block_end && !xfer_abort_bit;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      bus_rdata_o <= `READ_ZERO;
    end else if (bus_rd_i && buf_hit) begin
      bus_rdata_o <= data_buffer_area[buf_idx];
    end else if (bus_rd_i && (bus_addr_i == `ADDR_STATUS)) begin
      bus_rdata_o <= {xfer_active_flag, shift_active_flag, 6'h00};
    end else begin
      bus_rdata_o <= `READ_ZERO;
    end
  end

  // =====================================================
  // assertions
  irq_on_block_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    block_end && !xfer_abort_bit |=> serial_done_irq_o ##1 !serial_done_irq_o)
    else $error("no single interrupt pulse after last word");
  abort_ends_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    xfer_abort_bit && !wr_c1 |=> !xfer_active_flag && !xfer_abort_bit)
    else $error("abort did not end transfer or clear itself");
  start_goes_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state == S_IDLE) && go_req && (clk_sel != `CLK_RESERVED) && !xfer_abort_bit |=>
      shift_active_flag && (word_idx == 3'h0))
    else $error("start did not begin at lowest word");
  nibble_zero_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    word_end && rx_en && four |=> data_buffer_area[$past(word_idx)][7:4] == 4'h0)
    else $error("received nibble high bits not zero");
  count_kept_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    block_end && !wr_c2 |=> (word_count == $past(word_count)) && (word_idx == 3'h0))
    else $error("word count or index wrong after block");
  status_read_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    bus_rd_i && (bus_addr_i == `ADDR_STATUS) |=>
      (bus_rdata_o[7] == $past(xfer_active_flag)) && (bus_rdata_o[6] == $past(shift_active_flag)))
    else $error("status bits do not match state");
  idle_clock_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !shift_active_flag ##1 !shift_active_flag |-> sck_out_o)
    else $error("serial clock moved outside shifting");
  auto_hold_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (state == S_AUTO_WAIT) && !touched && !sw_access && !wr_c1 && xfer_start_bit && !xfer_abort_bit |=>
      (state == S_AUTO_WAIT) [*2])
    else $error("automatic wait released without buffer access");
  gap_entry_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    word_end && !block_end && gap_on && xfer_start_bit && !xfer_abort_bit |=> state == S_FRAME_GAP)
    else $error("frame pause not applied");
  lsb_out_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    fall && tx_en && !xfer_abort_bit |=> so_o == $past(shreg[0]))
    else $error("transmit bit not lsb on falling edge");
  stop_end_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    word_end && !xfer_start_bit |=> !xfer_active_flag)
    else $error("stop did not drop active flag at word end");
endmodule
